// *** flpc_pkg.sv ***
// Constants, types and encodings for the fabric login parameter codec.
// Assumes a single 100 MHz clock and that every user of it names items as flpc_pkg::name.
//
// Function
// - Common word 1 bits 15-0 carry the binary largest receivable data field size.
// - Sizes below 256 or above 2112 are invalid and never advertised.
// - Advertised size is always a multiple of four bytes.
// - Resolution bit 26 clear: timeout value counts 1 ms steps.
// - Resolution bit 26 set: timeout value counts 1 ns steps.
// - Classes 1, 2, 4: class word 0 bit 23 shows priority/preemption support.
// - Class 3 word 0 bit 23 is reserved, driven zero.
// - Services bit 10 set only when routing to multicast server exists.
// - Services bit 9 set only when routing to clock sync server exists.
// - Services bit 8 set only when routing to key distribution server exists.
// - Services bit 7 set only when routing to alias server exists.
// - Services bit 6 set only when routing to QoS facilitator exists.
// - Services bit 5 set only when routing to management server exists.
// - Services bit 4 set only when routing to time server exists.
// - Services bit 3 set only when routing to directory server exists.
// - Services word 0 bits 31-11, 2-0 and words 1-7 are reserved zero.

`default_nettype none

package flpc_pkg;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam logic [15:0] RX_SIZE_MIN  = 16'h0100;
    localparam logic [15:0] RX_SIZE_MAX  = 16'h0840;
    localparam logic [15:0] RX_SIZE_ALGN = 16'hfffc;
    localparam int          BIT_TOV_RES  = 26;
    localparam int          BIT_PRIO     = 23;
    localparam int          CLASS3_POS   = 2;
    localparam int          NUM_CLASSES  = 4;
    localparam int          SVC_LSB      = 3;
    localparam int          SVC_COUNT    = 8;

    // ----------------------------------------------------------------
    // Reply word order
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_COMMON_W1 = 4'h0;
    localparam logic [3:0] IDX_COMMON_W3 = 4'h1;
    localparam logic [3:0] IDX_CLASS_LO  = 4'h2;
    localparam logic [3:0] IDX_CLASS_HI  = 4'h5;
    localparam logic [3:0] IDX_SVC_W0    = 4'h6;
    localparam logic [3:0] IDX_LAST      = 4'hd;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          MS_IN_NS      = 1000000;
    localparam int          MS_CYCLES     = MS_IN_NS / CLK_PERIOD_NS;
    localparam logic [32:0] NS_PER_CYCLE  = 33'(CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SEND
    } flpc_state_type;

    typedef struct packed {
        flpc_state_type st;
        logic [3:0]     idx;
        logic [31:0]    data;
        logic [15:0]    size;
        logic           size_err;
        logic [31:0]    tov;
        logic           ns_res;
        logic [3:0]     prio;
        logic [7:0]     route;
        logic           done;
    } flpc_codec_type;

    typedef struct packed {
        logic        run;
        logic [31:0] presc;
        logic [31:0] elapsed;
        logic        expired;
    } flpc_timer_type;

    localparam flpc_codec_type CODEC_RESET = '0;
    localparam flpc_timer_type TIMER_RESET = '0;

endpackage

`default_nettype wire

// *** flpc_tov_timer.sv ***
// Error-detect timeout timer for the fabric login parameter codec.
// Assumes start and stop are synchronous pulses and tov/ns_res hold while running.

`timescale 1ns/1ps
`default_nettype none

module flpc_tov_timer #(
    parameter int MS_CYCLES = flpc_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Control
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [31:0] tov,
    input  wire logic        ns_res,
    // Status
    output logic             running,
    output logic             expired
);

    flpc_pkg::flpc_timer_type s_ff;
    flpc_pkg::flpc_timer_type nxt_s;
    logic [32:0]              ns_sum;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.expired = 1'b0;
        ns_sum        = {1'b0, s_ff.elapsed} + flpc_pkg::NS_PER_CYCLE;
        if (stop) begin
            nxt_s.run = 1'b0;
        end else if (start) begin
            nxt_s.run     = 1'b1;
            nxt_s.presc   = '0;
            nxt_s.elapsed = '0;
        end else if (s_ff.run) begin
            if (s_ff.elapsed >= tov) begin
                nxt_s.run     = 1'b0;
                nxt_s.expired = 1'b1;
            end else if (ns_res) begin
                // Saturate so a huge count cannot wrap back below tov
                nxt_s.elapsed = ns_sum[32] ? 32'hffffffff : ns_sum[31:0];
            end else if (s_ff.presc == 32'(MS_CYCLES - 1)) begin
                nxt_s.presc   = '0;
                nxt_s.elapsed = s_ff.elapsed + 32'h00000001;
            end else begin
                nxt_s.presc = s_ff.presc + 32'h00000001;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= flpc_pkg::TIMER_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign running = s_ff.run;
    assign expired = s_ff.expired;

endmodule

`default_nettype wire

// *** flpc_codec.sv ***
// Fabric port service parameter builder for the login reply.
// Assumes configuration inputs are synchronous to clock; the reply
// words leave one at a time under a valid/ready handshake.

`timescale 1ns/1ps
`default_nettype none

module flpc_codec #(
    parameter int MS_CYCLES = flpc_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,

    // Configuration from the fabric port
    input  wire logic [15:0] cfg_rx_size,
    input  wire logic [31:0] cfg_tov,
    input  wire logic        cfg_tov_ns,
    input  wire logic [3:0]  cfg_prio,
    input  wire logic [7:0]  cfg_route,

    // Build request
    input  wire logic        build_req,
    output logic             build_busy,
    output logic             build_done,

    // Reply word stream
    output logic             word_valid,
    input  wire logic        word_ready,
    output logic [31:0]      word_data,
    output logic [3:0]       word_idx,
    output logic             word_last,

    // Advertised snapshot
    output logic [15:0]      adv_rx_size,
    output logic             size_err,
    output logic             adv_tov_ns,

    // Timeout timer
    input  wire logic        tov_start,
    input  wire logic        tov_stop,
    output logic             tov_running,
    output logic             tov_expired
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    flpc_pkg::flpc_codec_type s_ff;
    flpc_pkg::flpc_codec_type nxt_s;

    logic [31:0] class_word [flpc_pkg::NUM_CLASSES];
    logic [31:0] common_w1;
    logic [31:0] common_w3;
    logic [31:0] svc_w0;
    logic [15:0] cfg_size_legal;
    logic        cfg_size_bad;
    logic [3:0]  next_idx;
    logic [31:0] next_word;

    // ----------------------------------------------------------------
    // Receive size check
    // ----------------------------------------------------------------
    // An illegal request is never sent as is: it is clamped to the nearest
    // limit or rounded down to a multiple of four; size_err reports the substitution.
    always_comb begin
        cfg_size_bad = 1'b0;
        if (cfg_rx_size < flpc_pkg::RX_SIZE_MIN) begin
            cfg_size_legal = flpc_pkg::RX_SIZE_MIN;
            cfg_size_bad   = 1'b1;
        end else if (cfg_rx_size > flpc_pkg::RX_SIZE_MAX) begin
            cfg_size_legal = flpc_pkg::RX_SIZE_MAX;
            cfg_size_bad   = 1'b1;
        end else begin
            // Rounding down stays legal: both limits are aligned
            cfg_size_legal = cfg_rx_size & flpc_pkg::RX_SIZE_ALGN;
            if (cfg_size_legal != cfg_rx_size) begin
                cfg_size_bad = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Common words
    // ----------------------------------------------------------------
    always_comb begin
        common_w1                        = '0;
        common_w1[15:0]                  = s_ff.size;
        common_w1[flpc_pkg::BIT_TOV_RES] = s_ff.ns_res;
    end

    // The count is sent as stored; bit 26 alone picks its unit
    assign common_w3 = s_ff.tov;

    // ----------------------------------------------------------------
    // Class words
    // ----------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < flpc_pkg::NUM_CLASSES; c++) begin : g_class
            always_comb begin
                class_word[c] = '0;
                if (c == flpc_pkg::CLASS3_POS) begin
                    class_word[c][flpc_pkg::BIT_PRIO] = 1'b0;
                end else begin
                    class_word[c][flpc_pkg::BIT_PRIO] = s_ff.prio[c];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Services availability word 0
    // ----------------------------------------------------------------
    // Route bit 7 is the multicast server at FFFF5 down to route
    // bit 0, the directory server at FFFFC.
    always_comb begin
        svc_w0 = '0;
        svc_w0[10] = s_ff.route[7];
        svc_w0[9]  = s_ff.route[6];
        svc_w0[8]  = s_ff.route[5];
        svc_w0[7]  = s_ff.route[4];
        svc_w0[6]  = s_ff.route[3];
        svc_w0[5]  = s_ff.route[2];
        svc_w0[4]  = s_ff.route[1];
        svc_w0[3]  = s_ff.route[0];
    end

    // ----------------------------------------------------------------
    // Word select
    // ----------------------------------------------------------------
    function automatic logic [31:0] pick_word(
        input logic [3:0]  idx,
        input logic [31:0] w1,
        input logic [31:0] w3,
        input logic [31:0] cw0,
        input logic [31:0] cw1,
        input logic [31:0] cw2,
        input logic [31:0] cw3,
        input logic [31:0] sw0
    );
        logic [31:0] w;
        w = '0;
        unique case (idx)
            flpc_pkg::IDX_COMMON_W1: w = w1;
            flpc_pkg::IDX_COMMON_W3: w = w3;
            4'h2:                    w = cw0;
            4'h3:                    w = cw1;
            4'h4:                    w = cw2;
            flpc_pkg::IDX_CLASS_HI:  w = cw3;
            flpc_pkg::IDX_SVC_W0:    w = sw0;
            // Services words 1 to 7 and unused codes
            default:                 w = '0;
        endcase
        return w;
    endfunction

    assign next_idx = (s_ff.st == flpc_pkg::ST_SEND) ? s_ff.idx + 4'h1
                                                       : flpc_pkg::IDX_COMMON_W1;

    assign next_word = pick_word(next_idx,
                                 common_w1,
                                 common_w3,
                                 class_word[0],
                                 class_word[1],
                                 class_word[2],
                                 class_word[3],
                                 svc_w0);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // The snapshot is frozen for a whole reply so every word agrees;
    // a build request while busy is ignored for the same reason.
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;
        unique case (s_ff.st)
            flpc_pkg::ST_IDLE: begin
                if (build_req) begin
                    nxt_s.size     = cfg_size_legal;
                    nxt_s.size_err = cfg_size_bad;
                    nxt_s.tov      = cfg_tov;
                    nxt_s.ns_res   = cfg_tov_ns;
                    nxt_s.prio     = cfg_prio;
                    nxt_s.route    = cfg_route;
                    nxt_s.idx      = flpc_pkg::IDX_COMMON_W1;
                    nxt_s.st       = flpc_pkg::ST_LOAD;
                end
            end
            flpc_pkg::ST_LOAD: begin
                nxt_s.data = next_word;
                nxt_s.idx  = next_idx;
                nxt_s.st   = flpc_pkg::ST_SEND;
            end
            flpc_pkg::ST_SEND: begin
                if (word_ready) begin
                    if (s_ff.idx == flpc_pkg::IDX_LAST) begin
                        nxt_s.st   = flpc_pkg::ST_IDLE;
                        nxt_s.done = 1'b1;
                        nxt_s.data = '0;
                        nxt_s.idx  = flpc_pkg::IDX_COMMON_W1;
                    end else begin
                        nxt_s.data = next_word;
                        nxt_s.idx  = next_idx;
                    end
                end
            end
            default: begin
                nxt_s = flpc_pkg::CODEC_RESET;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= flpc_pkg::CODEC_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign word_valid  = (s_ff.st == flpc_pkg::ST_SEND);
    assign word_data   = s_ff.data;
    assign word_idx    = s_ff.idx;
    assign word_last   = word_valid && (s_ff.idx == flpc_pkg::IDX_LAST);
    assign build_busy  = (s_ff.st != flpc_pkg::ST_IDLE);
    assign build_done  = s_ff.done;
    assign adv_rx_size = s_ff.size;
    assign size_err    = s_ff.size_err;
    assign adv_tov_ns  = s_ff.ns_res;

    // ----------------------------------------------------------------
    // Timeout timer
    // ----------------------------------------------------------------
    // Runs from the advertised snapshot so the local timer and the
    // node port read the same value in the same unit.
    flpc_tov_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tov_timer (
        .clock   (clock),
        .rst_b   (rst_b),
        .start   (tov_start),
        .stop    (tov_stop),
        .tov     (s_ff.tov),
        .ns_res  (s_ff.ns_res),
        .running (tov_running),
        .expired (tov_expired)
    );

endmodule

`default_nettype wire

// *** flpc_codec_monitor.sv ***
// Checker for the login parameter codec, bound to its top module.
// Assumes the single clock domain and the active-low reset of the codec.
`timescale 1ns/1ps
`default_nettype none
module flpc_codec_monitor #(
    parameter int MS_CYCLES = 4
) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [31:0] cfg_tov,
    input wire logic        cfg_tov_ns,
    input wire logic [3:0]  cfg_prio,
    input wire logic [7:0]  cfg_route,
    input wire logic        build_req,
    input wire logic        build_busy,
    input wire logic        build_done,
    input wire logic        word_valid,
    input wire logic        word_ready,
    input wire logic [31:0] word_data,
    input wire logic [3:0]  word_idx,
    input wire logic        word_last,
    input wire logic [15:0] adv_rx_size,
    input wire logic        adv_tov_ns,
    input wire logic        tov_start,
    input wire logic        tov_stop,
    input wire logic        tov_running,
    input wire logic        tov_expired
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [7:0]  route_ff;
    logic [3:0]  prio_ff;
    logic [31:0] tov_ff;
    // Own copy of timeout, priority and route so those word checks do not trust the design's copy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            route_ff <= 8'h00;
            prio_ff  <= 4'h0;
            tov_ff   <= 32'h0;
        end else if (build_req && !build_busy) begin
            route_ff <= cfg_route;
            prio_ff  <= cfg_prio;
            tov_ff   <= cfg_tov;
        end
    end
    sequence s_take; build_req && !build_busy; endsequence
    sequence s_first; build_busy ##1 (word_valid && word_idx == 4'h0); endsequence
    property p_walk; s_take |=> s_first; endproperty
    a_walk: assert property (p_walk) else $error("reply did not start on time");
    property p_range; build_busy |-> adv_rx_size >= 16'h0100 && adv_rx_size <= 16'h0840;
    endproperty
    a_range: assert property (p_range) else $error("advertised size out of range");
    property p_algn; build_busy |-> adv_rx_size[1:0] == 2'h0; endproperty
    a_algn: assert property (p_algn) else $error("advertised size unaligned");
    property p_w1; word_valid && word_idx == 4'h0 |->
        word_data == {5'h00, adv_tov_ns, 10'h000, adv_rx_size}; endproperty
    a_w1: assert property (p_w1) else $error("common word 1 wrong");
    property p_res; s_take |=> adv_tov_ns == $past(cfg_tov_ns); endproperty
    a_res: assert property (p_res) else $error("resolution bit not taken");
    property p_w3; word_valid && word_idx == 4'h1 |-> word_data == tov_ff; endproperty
    a_w3: assert property (p_w3) else $error("timeout word wrong");
    property p_prio; word_valid && word_idx >= 4'h2 && word_idx <= 4'h5 && word_idx != 4'h4
        |-> word_data[23] == prio_ff[word_idx - 4'h2]; endproperty
    a_prio: assert property (p_prio) else $error("priority bit wrong");
    property p_cls3; word_valid && word_idx == 4'h4 |-> !word_data[23]; endproperty
    a_cls3: assert property (p_cls3) else $error("class 3 bit 23 set");
    property p_svc; word_valid && word_idx == 4'h6 |-> word_data[10:7] == route_ff[7:4];
    endproperty
    a_svc: assert property (p_svc) else $error("services word wrong");
    property p_svc_lo; word_valid && word_idx == 4'h6 |->
        word_data[6:3] == route_ff[3:0] && word_data[31:11] == 21'h0 && word_data[2:0] == 3'h0;
    endproperty
    a_svc_lo: assert property (p_svc_lo) else $error("svc low");
    property p_svc_hi; word_valid && word_idx > 4'h6 |-> word_data == 32'h0; endproperty
    a_svc_hi: assert property (p_svc_hi) else $error("reserved services word set");
    property p_hold; word_valid && !word_ready |=>
        word_valid && $stable(word_data) && $stable(word_idx); endproperty
    a_hold: assert property (p_hold) else $error("word changed while stalled");
    property p_done; word_valid && word_ready && word_last |=> build_done && !word_valid;
    endproperty
    a_done: assert property (p_done) else $error("done not after last word");
    property p_tmr; tov_start && !tov_stop |=> tov_running; endproperty
    a_tmr: assert property (p_tmr) else $error("timer did not start");
    property p_exp; tov_expired |-> !tov_running && $past(tov_running); endproperty
    a_exp: assert property (p_exp) else $error("expiry without a running timer");
endmodule
bind flpc_codec flpc_codec_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
    .clock(clock), .rst_b(rst_b), .cfg_tov(cfg_tov), .cfg_tov_ns(cfg_tov_ns),
    .cfg_prio(cfg_prio), .cfg_route(cfg_route), .build_req(build_req),
    .build_busy(build_busy), .build_done(build_done), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_idx(word_idx),
    .word_last(word_last), .adv_rx_size(adv_rx_size), .adv_tov_ns(adv_tov_ns),
    .tov_start(tov_start), .tov_stop(tov_stop), .tov_running(tov_running),
    .tov_expired(tov_expired));
`default_nettype wire

// *** flpc_node_model.sv ***
// Node port model: takes the reply words and decodes the parameters.
// Assumes the codec's valid/ready word stream; stall makes ready toggle.
`timescale 1ns/1ps
`default_nettype none
module flpc_node_model (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        stall,
    input  wire logic        word_valid,
    output logic             word_ready,
    input  wire logic [31:0] word_data,
    input  wire logic [3:0]  word_idx,
    output logic [31:0]      rx_words [14],
    output logic             size_bad,
    output logic [63:0]      tov_ns_val
);
    logic tgl_ff;
    logic res_ff;
    assign word_ready = stall ? tgl_ff : 1'b1;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tgl_ff     <= 1'b0;
            res_ff     <= 1'b0;
            size_bad   <= 1'b0;
            tov_ns_val <= 64'h0;
        end else begin
            tgl_ff <= !tgl_ff;
            if (word_valid && word_ready) begin
                rx_words[word_idx] <= word_data;
                if (word_idx == 4'h0) begin
                    // Flag rather than adopt an illegal size
                    size_bad <= word_data[15:0] < 16'h0100 || word_data[15:0] > 16'h0840
                                || word_data[1:0] != 2'h0;
                    res_ff   <= word_data[26];
                end
                if (word_idx == 4'h1) begin
                    tov_ns_val <= res_ff ? 64'(word_data) : word_data * 64'd1000000;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** flpc_codec_test.sv ***
// Self-checking bench for the login parameter codec.
// Assumes the node model as far side and a 4-cycle millisecond for speed.
`timescale 1ns/1ps
`default_nettype none
module flpc_codec_test;
    logic clock = 1'b0, rst_b = 1'b0, stall = 1'b0;
    logic [15:0] cfg_rx_size = 16'h0;
    logic [31:0] cfg_tov = 32'h0;
    logic cfg_tov_ns = 1'b0, build_req = 1'b0, tov_start = 1'b0, tov_stop = 1'b0;
    logic [3:0] cfg_prio = 4'h0;
    logic [7:0] cfg_route = 8'h0;
    logic build_busy, build_done, word_valid, word_ready, word_last, size_err, adv_tov_ns;
    logic tov_running, tov_expired, size_bad;
    logic [31:0] word_data;
    logic [3:0] word_idx;
    logic [15:0] adv_rx_size;
    logic [31:0] rx_words [14];
    logic [63:0] tov_ns_val;
    int errors = 0, checks = 0;
    // Awkward sizes: both limits, just outside them, unaligned
    logic [15:0] sizes [8] = '{16'h0100, 16'h0840, 16'h00ff, 16'h0841,
                               16'h0102, 16'h0203, 16'h0000, 16'hffff};
    flpc_codec #(.MS_CYCLES(4)) dut (.clock(clock), .rst_b(rst_b), .cfg_rx_size(cfg_rx_size),
        .cfg_tov(cfg_tov), .cfg_tov_ns(cfg_tov_ns), .cfg_prio(cfg_prio), .cfg_route(cfg_route),
        .build_req(build_req), .build_busy(build_busy), .build_done(build_done),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
        .word_idx(word_idx), .word_last(word_last), .adv_rx_size(adv_rx_size),
        .size_err(size_err), .adv_tov_ns(adv_tov_ns), .tov_start(tov_start),
        .tov_stop(tov_stop), .tov_running(tov_running), .tov_expired(tov_expired));
    flpc_node_model u_node (.clock(clock), .rst_b(rst_b), .stall(stall),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
        .word_idx(word_idx), .rx_words(rx_words), .size_bad(size_bad), .tov_ns_val(tov_ns_val));
    initial begin
        forever #5 clock = !clock;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_for(input logic pick, input int lim, output int n);
        n = 0;
        while ((pick ? tov_expired : build_done) !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > lim) begin
                errors++;
                give_verdict();
            end
        end
    endtask
    task automatic build(input logic [15:0] sz, input logic ns, input logic [3:0] pr,
                         input logic [7:0] rt);
        int n;
        logic [15:0] exp;
        exp = sz < 16'h0100 ? 16'h0100 : sz > 16'h0840 ? 16'h0840 : sz & 16'hfffc;
        @(posedge clock);
        cfg_rx_size <= sz;
        cfg_tov <= ns ? 32'd30 : 32'd2;
        cfg_tov_ns <= ns;
        cfg_prio <= pr;
        cfg_route <= rt;
        build_req <= 1'b1;
        @(posedge clock);
        build_req <= 1'b0;
        wait_for(1'b0, 100, n);
        chk(adv_rx_size, exp);
        chk(size_err, exp != sz);
        chk(rx_words[0], {5'h0, ns, 10'h0, exp});
        chk(tov_ns_val, ns ? 64'd30 : 64'd2000000);
        chk(size_bad, 1'b0);
        for (int c = 0; c < 4; c++) begin
            chk(rx_words[2 + c], (pr[c] && c != 2) ? 32'h00800000 : 32'h0);
        end
        chk(rx_words[6], {21'h0, rt, 3'h0});
        for (int k = 7; k < 14; k++) chk(rx_words[k], 32'h0);
    endtask
    task automatic timer(input int lo, input int hi);
        int n;
        @(posedge clock);
        tov_start <= 1'b1;
        @(posedge clock);
        tov_start <= 1'b0;
        wait_for(1'b1, 40, n);
        chk(n + 1 >= lo && n + 1 <= hi, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            stall <= i[0];
            build(sizes[i], i[0], 4'hf ^ 4'(i), 8'h01 << i);
            if (i >= 6) timer(i[0] ? 4 : 9, i[0] ? 6 : 11);
        end
        // Stop right after start: no expiry may follow
        @(posedge clock);
        tov_start <= 1'b1;
        @(posedge clock);
        tov_start <= 1'b0;
        tov_stop <= 1'b1;
        @(posedge clock);
        tov_stop <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(posedge clock);
            #1;
            chk(tov_expired, 1'b0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
